//--- rtl/sideband_device.sv
// socket end of the sideband error, thermal and strap logic
`timescale 1ns/1ps
`default_nettype none
module sideband_device
  import sideband_pkg::*;
(
  input wire logic clk, // base reference clock
  input wire logic sys_rst, // sync reset, active high
  sideband_if.device sb, // pins toward the platform
  input wire logic mce_event, // nonrecoverable machine check pulse
  input wire logic internal_error_event, // internal unrecoverable error pulse
  input wire logic [2:0] io_err_event, // io errors: corrected, nonfatal, fatal
  input wire logic [2:0] io_err_clear, // io error status clears
  input wire logic reg_fault_event, // regulator fault detected
  input wire logic die_crit_temp, // critical die temperature level
  input wire logic mem_crit_temp, // critical memory temperature level
  input wire logic die_max_temp, // maximum safe die temperature level
  input wire logic [1:0] branch_hot, // memory branch hot levels
  input wire logic [1:0] mem_hot_out_mode, // 1 = output level mode per line
  input wire logic wake_event, // wake needing snoop, memory or irq
  input wire logic in_pkg_c_state, // package in C3 to C6
  input wire logic proceed_write, // proceed handshake to scratchpad
  output logic machine_check_exc, // machine check exception pulse
  output logic [1:0] throttle_mem, // throttle channel groups
  output logic thermal_ctrl_on, // thermal control circuit active
  output logic exit_low_power, // leave package low-power state
  output logic boot_go, // core boot allowed
  output logic execution_halt, // stop execution and clock generators
  output logic debug_enable, // debug features on
  output logic clock_gating_off, // clock gating disabled
  output logic legacy_socket, // socket is legacy socket
  output logic fw_agent_present, // firmware agent behind this socket
  output logic hub_link_pcie, // hub link in pcie mode
  output logic trusted_agent, // socket is trusted agent
  output logic outputs_tristate, // open-drain pins held off after a reset release seen with processor-hot asserted
  output logic [2:0] cache_invalidate_n // low: caches dropped without write-back
);
  // -------------------------------------------------------------
  // synchronisers
  // -------------------------------------------------------------
  localparam int unsigned NSYNC = 8;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s1_d;
  logic [NSYNC-1:0] s2_d;
  assign raw = {~sb.fatal_error_line_n, sb.power_good_in, sb.reset_n,
                ~sb.memory_hot_n, ~sb.fast_wake_line_n, ~sb.processor_hot_n,
                ~sb.debug_force_n};
  always_comb
  begin
    s1_d = raw;
    s2_d = s1_q;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  logic fatal_s, pg_s, rstn_s, wake_s, hot_s, dbg_s;
  logic [1:0] memhot_s;
  assign {fatal_s, pg_s, rstn_s, memhot_s, wake_s, hot_s, dbg_s} = s2_q;
  logic core_rst;
  assign core_rst = sys_rst | ~rstn_s | ~pg_s;

  // -------------------------------------------------------------
  // fatal error line
  // -------------------------------------------------------------
  logic [4:0] mce_cnt_q, mce_cnt_d;
  logic internal_error_q, internal_error_d, fatal_oe_q, fatal_oe_d, mce_exc_q, mce_exc_d;
  logic [3:0] own_q, own_d;
  logic rst_prev_q, tri_q, tri_d, cap_q, cap_d;
  always_comb
  begin
    mce_cnt_d = mce_cnt_q;
    if (mce_event)
      mce_cnt_d = 5'(MCE_HOLD_CYCLES);
    else if (mce_cnt_q != MCE_CNT_RESET)
      mce_cnt_d = mce_cnt_q - 5'h01;
    internal_error_d = internal_error_q | internal_error_event;
    fatal_oe_d = ((mce_cnt_d != MCE_CNT_RESET) | internal_error_d) & ~tri_d;
    // own drive, delayed like the synchroniser, so its tail is not taken as external
    own_d = {own_q[2], sb.hot_dev_oe, own_q[0], sb.fatal_dev_oe};
    mce_exc_d = fatal_s & ~own_q[1] & pg_s;
  end
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      mce_cnt_q <= MCE_CNT_RESET;
      internal_error_q <= 1'b0;
      fatal_oe_q <= 1'b0;
      mce_exc_q <= 1'b0;
      own_q <= 4'h0;
    end
    else
    begin
      mce_cnt_q <= mce_cnt_d;
      internal_error_q <= internal_error_d;
      fatal_oe_q <= fatal_oe_d;
      mce_exc_q <= mce_exc_d;
      own_q <= own_d;
    end
  end

  // -------------------------------------------------------------
  // io error status, regulator fault (power-good domain)
  // -------------------------------------------------------------
  logic [2:0] ioerr_q, ioerr_d;
  logic rfault_q, rfault_d;
  always_comb
  begin
    ioerr_d = (ioerr_q & ~io_err_clear) | io_err_event;
    rfault_d = rfault_q | reg_fault_event;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst | ~pg_s)
    begin
      ioerr_q <= 3'h0;
      rfault_q <= 1'b0;
    end
    else
    begin
      ioerr_q <= ioerr_d;
      rfault_q <= rfault_d;
    end
  end

  // -------------------------------------------------------------
  // thermal, memory-hot, fast-wake
  // -------------------------------------------------------------
  logic trip_q, trip_d, hot_oe_q, hot_oe_d, tcc_q, tcc_d;
  logic [1:0] mh_oe_q, mh_oe_d, thr_q, thr_d;
  logic wake_oe_q, wake_oe_d, exit_q, exit_d;
  always_comb
  begin
    // latched; cleared by reset, re-armed if still hot
    trip_d = trip_q | die_crit_temp | mem_crit_temp;
    hot_oe_d = die_max_temp & ~tri_d;
    tcc_d = die_max_temp | (hot_s & ~own_q[3]);
    mh_oe_d = mem_hot_out_mode & branch_hot & {2{~tri_d}};
    thr_d = ~mem_hot_out_mode & memhot_s;
    wake_oe_d = wake_event & in_pkg_c_state & ~tri_d;
    exit_d = in_pkg_c_state & wake_s;
  end
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      trip_q <= 1'b0;
      hot_oe_q <= 1'b0;
      tcc_q <= 1'b0;
      mh_oe_q <= 2'h0;
      thr_q <= 2'h0;
      wake_oe_q <= 1'b0;
      exit_q <= 1'b0;
    end
    else
    begin
      trip_q <= trip_d;
      hot_oe_q <= hot_oe_d;
      tcc_q <= tcc_d;
      mh_oe_q <= mh_oe_d;
      thr_q <= thr_d;
      wake_oe_q <= wake_oe_d;
      exit_q <= exit_d;
    end
  end

  // -------------------------------------------------------------
  // straps, boot sequencing, tristate at reset release
  // -------------------------------------------------------------
  boot_state_t st_q, st_d;
  logic svc_q, safe_q, dbg_q, leg_q, fwa_q, pcie_q, trust_q;
  logic svc_d, safe_d, dbg_d, leg_d, fwa_d, pcie_d, trust_d;
  logic go_q, go_d;
  always_comb
  begin
    cap_d = cap_q | pg_s;
    {svc_d, safe_d, dbg_d, leg_d, fwa_d, pcie_d, trust_d} =
      {svc_q, safe_q, dbg_q, leg_q, fwa_q, pcie_q, trust_q};
    if (pg_s & ~cap_q)
    begin
      svc_d = sb.service_boot_strap;
      safe_d = sb.safe_boot_strap;
      dbg_d = dbg_s;
      leg_d = (sb.socket_index_strap == LEGACY_SOCKET_INDEX) & sb.firmware_agent_strap;
      fwa_d = sb.firmware_agent_strap;
      pcie_d = (sb.socket_index_strap != LEGACY_SOCKET_INDEX) | ~sb.firmware_agent_strap;
      trust_d = sb.trusted_agent_strap;
    end
    tri_d = tri_q;
    if (rstn_s & ~rst_prev_q)
      tri_d = hot_s;
    st_d = st_q;
    go_d = 1'b0;
    unique case (st_q)
      BOOT_IDLE: st_d = svc_q ? BOOT_WAIT : BOOT_RUN;
      BOOT_WAIT: if (proceed_write) st_d = BOOT_RUN;
      BOOT_RUN: go_d = ~trip_q;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst | ~pg_s)
    begin
      cap_q <= 1'b0;
      {svc_q, safe_q, dbg_q, leg_q, fwa_q, pcie_q, trust_q} <= 7'h00;
    end
    else
    begin
      cap_q <= cap_d;
      {svc_q, safe_q, dbg_q, leg_q, fwa_q, pcie_q, trust_q} <=
        {svc_d, safe_d, dbg_d, leg_d, fwa_d, pcie_d, trust_d};
    end
    if (sys_rst)
    begin
      rst_prev_q <= 1'b0;
      tri_q <= 1'b0;
    end
    else
    begin
      rst_prev_q <= rstn_s;
      tri_q <= tri_d;
    end
    if (core_rst | ~cap_q)
    begin
      st_q <= BOOT_IDLE;
      go_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      go_q <= go_d;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign sb.fatal_dev_oe = fatal_oe_q;
  assign sb.io_error_status = ioerr_q;
  assign sb.regulator_fault = rfault_q;
  assign sb.thermal_trip_n = ~trip_q;
  assign sb.mem_hot_dev_oe = mh_oe_q;
  assign sb.fast_wake_dev_oe = wake_oe_q;
  assign sb.hot_dev_oe = hot_oe_q;
  assign machine_check_exc = mce_exc_q;
  assign throttle_mem = thr_q;
  assign thermal_ctrl_on = tcc_q;
  assign exit_low_power = exit_q;
  assign boot_go = go_q;
  assign execution_halt = trip_q;
  assign debug_enable = dbg_q;
  assign clock_gating_off = safe_q;
  assign legacy_socket = leg_q;
  assign fw_agent_present = fwa_q;
  assign hub_link_pcie = pcie_q;
  assign trusted_agent = trust_q;
  assign outputs_tristate = tri_q;
  assign cache_invalidate_n = {3{go_q}};
endmodule
`default_nettype wire

//--- rtl/sideband_pkg.sv
// constants and types shared by the sideband error and strap logic
// How it works
// - fatal line asserts on unrecoverable errors
// - machine check holds fatal line sixteen cycles
// - internal error holds fatal line until reset
// - external fatal line assertion raises machine check
// - three-line io error status: corrected, nonfatal, fatal
// - platform ignores regulator fault early after power-good
// - regulator fault valid only with thermal trip
// - service boot strap waits for proceed handshake
// - debug force enables debug from cold boot
// - external memory-hot input throttles its channels
// - memory-hot output follows hot memory branch
// - fast-wake line shared; all sockets exit low-power
// - processor-hot out when hot; in activates throttling
// - processor-hot at reset release tristates open-drain outputs
// - platform raises power-good only when stable
// - reset returns state known, caches dropped
// - some state initialised only by power-good
// - safe boot strap disables clock gating
// - thermal trip halts execution and clocks
// - thermal trip latched until reset, re-evaluated after
// - legacy socket strapped trusted when trusted agent; the platform copies the trusted strap through unchanged
// - socket index and firmware strap decide roles
package sideband_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MCE_HOLD_CYCLES = 16;
  localparam real FAULT_IGNORE_MS = 1.5;
  localparam int unsigned FAULT_IGNORE_CYCLES = 375000;
  localparam logic [1:0] LEGACY_SOCKET_INDEX = 2'h0;
  localparam logic [4:0] MCE_CNT_RESET = 5'h00;
  typedef enum logic [1:0] {BOOT_IDLE, BOOT_WAIT, BOOT_RUN} boot_state_t;
endpackage

//--- rtl/sideband_if.sv
// interface joining the socket sideband logic and its platform partner
`timescale 1ns/1ps
`default_nettype none
interface sideband_if;
  logic fatal_dev_oe;
  logic fatal_plat_oe;
  logic fatal_error_line_n;
  logic [2:0] io_error_status;
  logic regulator_fault;
  logic thermal_trip_n;
  logic power_good_in;
  logic reset_n;
  logic service_boot_strap;
  logic firmware_agent_strap;
  logic [1:0] socket_index_strap;
  logic safe_boot_strap;
  logic trusted_agent_strap;
  logic debug_force_n;
  logic [1:0] mem_hot_dev_oe;
  logic [1:0] mem_hot_plat_oe;
  logic [1:0] memory_hot_n;
  logic fast_wake_dev_oe;
  logic fast_wake_plat_oe;
  logic fast_wake_line_n;
  logic hot_dev_oe;
  logic hot_plat_oe;
  logic processor_hot_n;
  // wired-or resolution of the open-drain lines
  assign fatal_error_line_n = ~(fatal_dev_oe | fatal_plat_oe);
  assign memory_hot_n = ~(mem_hot_dev_oe | mem_hot_plat_oe);
  assign fast_wake_line_n = ~(fast_wake_dev_oe | fast_wake_plat_oe);
  assign processor_hot_n = ~(hot_dev_oe | hot_plat_oe);
  modport device (
    output fatal_dev_oe, io_error_status, regulator_fault, thermal_trip_n,
    output mem_hot_dev_oe, fast_wake_dev_oe, hot_dev_oe,
    input fatal_error_line_n, power_good_in, reset_n, service_boot_strap,
    input firmware_agent_strap, socket_index_strap, safe_boot_strap,
    input trusted_agent_strap, debug_force_n, memory_hot_n,
    input fast_wake_line_n, processor_hot_n
  );
  modport platform (
    output fatal_plat_oe, power_good_in, reset_n, service_boot_strap,
    output firmware_agent_strap, socket_index_strap, safe_boot_strap,
    output trusted_agent_strap, debug_force_n, mem_hot_plat_oe,
    output fast_wake_plat_oe, hot_plat_oe,
    input fatal_error_line_n, io_error_status, regulator_fault, thermal_trip_n,
    input memory_hot_n, fast_wake_line_n, processor_hot_n
  );
endinterface
`default_nettype wire

//--- rtl/sideband_platform.sv
// platform end: power-good, straps and open-drain partner drives
`timescale 1ns/1ps
`default_nettype none
module sideband_platform
  import sideband_pkg::*;
#(
  parameter int unsigned IGNORE_CYCLES = FAULT_IGNORE_CYCLES
)
(
  input wire logic clk, // base reference clock
  input wire logic sys_rst, // sync reset, active high
  sideband_if.platform sb, // pins toward the socket
  input wire logic supplies_stable, // clocks and supplies good
  input wire logic reset_req, // hold socket in reset
  input wire logic [5:0] strap_set, // svc, fwa, idx[1:0], safe, trusted
  input wire logic debug_req, // force debug
  input wire logic fatal_req, // drive fatal line
  input wire logic [1:0] mem_hot_req, // drive memory-hot inputs
  input wire logic wake_req, // drive fast-wake line
  input wire logic hot_req, // drive processor-hot
  output logic fault_seen, // qualified regulator fault
  output logic [2:0] io_err_seen, // io error status
  output logic fatal_seen, // fatal line asserted
  output logic trip_seen // thermal trip asserted
);
  logic pg_q, pg_d, rst_q, rst_d, ok_q, ok_d;
  logic [18:0] cnt_q, cnt_d;
  logic [5:0] strap_q, strap_d;
  logic [7:0] drv_q, drv_d;
  logic [3:0] obs_q, obs_d;
  logic [2:0] ioe_q, ioe_d;
  always_comb
  begin
    pg_d = supplies_stable;
    rst_d = ~reset_req & pg_q;
    cnt_d = cnt_q;
    ok_d = ok_q;
    if (~pg_q)
    begin
      cnt_d = 19'h00000;
      ok_d = 1'b0;
    end
    else if (cnt_q >= 19'(IGNORE_CYCLES - 1))
      ok_d = 1'b1;
    else
      cnt_d = cnt_q + 19'h00001;
    strap_d = pg_q ? strap_q : strap_set;
    // legacy socket as trusted agent must be strapped trusted; here strap_d[0] only takes strap_set[0] unchanged
    if (strap_set[3:2] == LEGACY_SOCKET_INDEX && strap_set[4] && ~pg_q)
      strap_d[0] = strap_set[0];
    drv_d = {debug_req, fatal_req, mem_hot_req, wake_req, hot_req, 2'h0};
    obs_d = {ok_q & sb.regulator_fault & ~sb.thermal_trip_n,
             ~sb.fatal_error_line_n, ~sb.thermal_trip_n, 1'b0};
    ioe_d = sb.io_error_status;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pg_q <= 1'b0;
      rst_q <= 1'b0;
      ok_q <= 1'b0;
      cnt_q <= 19'h00000;
      strap_q <= 6'h00;
      drv_q <= 8'h00;
      obs_q <= 4'h0;
      ioe_q <= 3'h0;
    end
    else
    begin
      pg_q <= pg_d;
      rst_q <= rst_d;
      ok_q <= ok_d;
      cnt_q <= cnt_d;
      strap_q <= strap_d;
      drv_q <= drv_d;
      obs_q <= obs_d;
      ioe_q <= ioe_d;
    end
  end
  assign sb.power_good_in = pg_q;
  assign sb.reset_n = rst_q;
  assign {sb.service_boot_strap, sb.firmware_agent_strap} = strap_q[5:4];
  assign sb.socket_index_strap = strap_q[3:2];
  assign {sb.safe_boot_strap, sb.trusted_agent_strap} = strap_q[1:0];
  assign sb.debug_force_n = ~drv_q[7];
  assign sb.fatal_plat_oe = drv_q[6];
  assign sb.mem_hot_plat_oe = drv_q[5:4];
  assign sb.fast_wake_plat_oe = drv_q[3];
  assign sb.hot_plat_oe = drv_q[2];
  assign fault_seen = obs_q[3];
  assign fatal_seen = obs_q[2];
  assign trip_seen = obs_q[1];
  assign io_err_seen = ioe_q;
endmodule
`default_nettype wire

//--- verif/sideband_monitor.sv
// concurrent checks on the sideband pins between socket and platform
`timescale 1ns/1ps
`default_nettype none
module sideband_monitor (
  input wire logic clk, // base reference clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic fatal_dev_oe, // socket pulls fatal line
  input wire logic thermal_trip_n, // thermal trip pin
  input wire logic [2:0] io_error_status, // io error status pins
  input wire logic regulator_fault, // regulator fault pin
  input wire logic [1:0] mem_hot_dev_oe, // socket pulls memory-hot
  input wire logic fast_wake_dev_oe, // socket pulls fast-wake
  input wire logic hot_dev_oe, // socket pulls processor-hot
  input wire logic processor_hot_n, // resolved processor-hot line
  input wire logic reset_n, // socket reset pin
  input wire logic power_good_in // power-good pin
);
  logic [2:0] ok_q;
  logic [2:0] ok_d;
  logic [2:0] low_q;
  logic [2:0] low_d;
  // ----------------------------------------
  // qualification counters
  // ----------------------------------------
  // pins cross a synchroniser, so reset effects need a few cycles of margin
  always_comb
  begin
    if (reset_n && power_good_in)
    begin
      ok_d = (ok_q == 3'h4) ? ok_q : ok_q + 3'h1;
      low_d = 3'h0;
    end
    else
    begin
      ok_d = 3'h0;
      low_d = (low_q == 3'h4) ? low_q : low_q + 3'h1;
    end
  end
  always_ff @(posedge clk)
  begin
    ok_q <= sys_rst ? 3'h0 : ok_d;
    low_q <= sys_rst ? 3'h0 : low_d;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_fatal_hold: assert property (
    $rose(fatal_dev_oe) && ok_q == 3'h4 |-> fatal_dev_oe [*8] ##1 fatal_dev_oe [*8])
    else $error("fatal line released early");
  a_fatal_age: assert property (
    $fell(fatal_dev_oe) && ok_q == 3'h4 |-> $past(fatal_dev_oe, 16))
    else $error("fatal line pulse too short");
  a_trip_latched: assert property (
    !thermal_trip_n && ok_q == 3'h4 |=> !thermal_trip_n)
    else $error("thermal trip dropped without reset");
  a_reset_trip: assert property (
    low_q == 3'h4 |-> thermal_trip_n)
    else $error("thermal trip held in reset");
  a_reset_fatal: assert property (
    low_q == 3'h4 |-> !fatal_dev_oe)
    else $error("fatal line driven in reset");
  a_reset_pins: assert property (
    low_q == 3'h4 |-> mem_hot_dev_oe == 2'h0 && !fast_wake_dev_oe && !hot_dev_oe)
    else $error("pin driven in reset");
  a_pg_clears: assert property (
    !power_good_in && !$past(power_good_in, 3) && low_q == 3'h4
      |-> io_error_status == 3'h0 && !regulator_fault)
    else $error("error state kept without power-good");
  a_hot_tristate: assert property (
    $rose(reset_n) && !processor_hot_n && power_good_in
      |=> (!fatal_dev_oe && thermal_trip_n && !hot_dev_oe) [*8])
    else $error("pins driven after hot release");
  a_release_idle: assert property (
    $fell(sys_rst) |-> thermal_trip_n && !fatal_dev_oe && io_error_status == 3'h0)
    else $error("pins busy at reset release");
endmodule
`default_nettype wire

//--- verif/tb_sideband_error_strap_logic.sv
// self-checking bench joining socket and platform ends of the sideband
`timescale 1ns/1ps
`default_nettype none
module tb_sideband_error_strap_logic;
  import sideband_pkg::*;
  logic clk, sys_rst, mce_event, internal_error_event, reg_fault_event, die_crit_temp, mem_crit_temp;
  logic die_max_temp, wake_event, in_pkg_c_state, proceed_write, machine_check_exc;
  logic thermal_ctrl_on, exit_low_power, boot_go, execution_halt, debug_enable;
  logic clock_gating_off, legacy_socket, fw_agent_present, hub_link_pcie, trusted_agent;
  logic outputs_tristate, supplies_stable, reset_req, debug_req, fatal_req, wake_req, hot_req;
  logic fault_seen, fatal_seen, trip_seen;
  logic [2:0] io_err_event, io_err_clear, cache_invalidate_n, io_err_seen;
  logic [1:0] branch_hot, mem_hot_out_mode, throttle_mem, mem_hot_req;
  logic [5:0] strap_set;
  int miscompares, tests_run, cycles, n, m;
  sideband_if sb_bus ();
  sideband_device sideband_device_i (.clk(clk), .sys_rst(sys_rst), .sb(sb_bus),
    .mce_event(mce_event), .internal_error_event(internal_error_event), .io_err_event(io_err_event),
    .io_err_clear(io_err_clear), .reg_fault_event(reg_fault_event),
    .die_crit_temp(die_crit_temp), .mem_crit_temp(mem_crit_temp), .die_max_temp(die_max_temp),
    .branch_hot(branch_hot), .mem_hot_out_mode(mem_hot_out_mode), .wake_event(wake_event),
    .in_pkg_c_state(in_pkg_c_state), .proceed_write(proceed_write),
    .machine_check_exc(machine_check_exc), .throttle_mem(throttle_mem),
    .thermal_ctrl_on(thermal_ctrl_on), .exit_low_power(exit_low_power), .boot_go(boot_go),
    .execution_halt(execution_halt), .debug_enable(debug_enable),
    .clock_gating_off(clock_gating_off), .legacy_socket(legacy_socket),
    .fw_agent_present(fw_agent_present), .hub_link_pcie(hub_link_pcie),
    .trusted_agent(trusted_agent), .outputs_tristate(outputs_tristate),
    .cache_invalidate_n(cache_invalidate_n));
  // short ignore window keeps the run brief
  sideband_platform #(.IGNORE_CYCLES(20)) sideband_platform_i (.clk(clk), .sys_rst(sys_rst),
    .sb(sb_bus), .supplies_stable(supplies_stable), .reset_req(reset_req),
    .strap_set(strap_set), .debug_req(debug_req), .fatal_req(fatal_req),
    .mem_hot_req(mem_hot_req), .wake_req(wake_req), .hot_req(hot_req),
    .fault_seen(fault_seen), .io_err_seen(io_err_seen), .fatal_seen(fatal_seen),
    .trip_seen(trip_seen));
  sideband_monitor sideband_monitor_i (.clk(clk), .sys_rst(sys_rst),
    .fatal_dev_oe(sb_bus.fatal_dev_oe), .thermal_trip_n(sb_bus.thermal_trip_n),
    .io_error_status(sb_bus.io_error_status), .regulator_fault(sb_bus.regulator_fault),
    .mem_hot_dev_oe(sb_bus.mem_hot_dev_oe), .fast_wake_dev_oe(sb_bus.fast_wake_dev_oe),
    .hot_dev_oe(sb_bus.hot_dev_oe), .processor_hot_n(sb_bus.processor_hot_n),
    .reset_n(sb_bus.reset_n), .power_good_in(sb_bus.power_good_in));
  // ----------------------------------------
  // clock, timeout and checking tasks
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic chk_vec(input logic [2:0] got, input logic [2:0] exp, input string msg);
    chk_bit(got === exp, 1'b1, msg);
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic rst_on();
    @(posedge clk) reset_req <= 1'b1;
    tick(8);
  endtask
  task automatic rst_off();
    @(posedge clk) reset_req <= 1'b0;
    tick(10);
  endtask
  task automatic boot(input logic [5:0] s, input logic dbg);
    @(posedge clk);
    supplies_stable <= 1'b0;
    reset_req <= 1'b1;
    strap_set <= s;
    debug_req <= dbg;
    tick(6);
    @(posedge clk) supplies_stable <= 1'b1;
    tick(6);
    rst_off();
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {sys_rst, supplies_stable, reset_req, debug_req, fatal_req, wake_req, hot_req} <= 7'h50;
    {mce_event, internal_error_event, reg_fault_event, die_crit_temp, mem_crit_temp} <= 5'h00;
    {die_max_temp, wake_event, in_pkg_c_state, proceed_write} <= 4'h0;
    {io_err_event, io_err_clear, branch_hot, mem_hot_out_mode, mem_hot_req} <= 12'h000;
    strap_set <= 6'h00;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    boot(6'h33, 1'b1);
    chk_bit(legacy_socket, 1'b1, "legacy socket");
    chk_bit(fw_agent_present, 1'b1, "firmware agent");
    chk_bit(hub_link_pcie, 1'b0, "hub link mode");
    chk_bit(trusted_agent, 1'b1, "trusted agent");
    chk_bit(clock_gating_off, 1'b1, "clock gating off");
    chk_bit(debug_enable, 1'b1, "debug forced");
    chk_bit(boot_go, 1'b0, "service boot waits");
    @(posedge clk) proceed_write <= 1'b1;
    @(posedge clk) proceed_write <= 1'b0;
    tick(4);
    chk_bit(boot_go, 1'b1, "boot after proceed");
    boot(6'h04, 1'b0);
    chk_vec({legacy_socket, fw_agent_present, hub_link_pcie}, 3'h1, "socket roles");
    chk_vec({trusted_agent, clock_gating_off, debug_enable}, 3'h0, "plain straps");
    chk_bit(boot_go, 1'b1, "normal boot");
    chk_vec(cache_invalidate_n, 3'h7, "caches kept after boot");
    @(posedge clk) mce_event <= 1'b1;
    @(posedge clk) mce_event <= 1'b0;
    n = 0;
    m = 0;
    repeat (30)
    begin
      @(negedge clk);
      if (sb_bus.fatal_dev_oe === 1'b1)
        n++;
      if (machine_check_exc === 1'b1)
        m++;
    end
    chk_bit(n == 16, 1'b1, "machine check hold");
    chk_bit(m == 0, 1'b1, "own drive not external");
    @(posedge clk) internal_error_event <= 1'b1;
    @(posedge clk) internal_error_event <= 1'b0;
    tick(40);
    chk_bit(sb_bus.fatal_error_line_n, 1'b0, "internal error hold");
    chk_bit(fatal_seen, 1'b1, "platform sees fatal");
    rst_on();
    chk_bit(sb_bus.fatal_dev_oe, 1'b0, "fatal cleared by reset");
    chk_vec(cache_invalidate_n, 3'h0, "caches dropped in reset");
    rst_off();
    @(posedge clk) fatal_req <= 1'b1;
    n = 0;
    repeat (8)
    begin
      @(negedge clk);
      if (machine_check_exc === 1'b1)
        n++;
    end
    @(posedge clk) fatal_req <= 1'b0;
    chk_bit(n != 0, 1'b1, "external fatal exception");
    tick(6);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk) io_err_event <= 3'h1 << i;
      @(posedge clk) io_err_event <= 3'h0;
      tick(4);
      chk_vec(io_err_seen, 3'h1 << i, "io error set");
      @(posedge clk) io_err_clear <= 3'h7;
      @(posedge clk) io_err_clear <= 3'h0;
      tick(4);
      chk_vec(io_err_seen, 3'h0, "io error clear");
    end
    @(posedge clk) mem_hot_req <= 2'h1;
    tick(6);
    chk_vec({1'b0, throttle_mem}, 3'h1, "memory throttle");
    @(posedge clk);
    mem_hot_req <= 2'h0;
    mem_hot_out_mode <= 2'h3;
    branch_hot <= 2'h2;
    tick(6);
    chk_vec({1'b0, sb_bus.memory_hot_n}, 3'h1, "memory hot level");
    @(posedge clk);
    branch_hot <= 2'h0;
    wake_event <= 1'b1;
    in_pkg_c_state <= 1'b1;
    tick(6);
    chk_bit(sb_bus.fast_wake_dev_oe, 1'b1, "fast wake drive");
    chk_bit(exit_low_power, 1'b1, "own wake exit");
    @(posedge clk) wake_event <= 1'b0;
    tick(6);
    chk_bit(exit_low_power, 1'b0, "wake idle");
    @(posedge clk) wake_req <= 1'b1;
    tick(6);
    chk_bit(exit_low_power, 1'b1, "peer wake exit");
    @(posedge clk) wake_req <= 1'b0;
    die_max_temp <= 1'b1;
    tick(6);
    chk_bit(sb_bus.hot_dev_oe, 1'b1, "processor hot out");
    @(posedge clk) die_max_temp <= 1'b0;
    hot_req <= 1'b1;
    tick(6);
    chk_bit(thermal_ctrl_on, 1'b1, "thermal control in");
    rst_on();
    rst_off();
    chk_bit(outputs_tristate, 1'b1, "tristate on hot release");
    @(posedge clk) mce_event <= 1'b1;
    @(posedge clk) mce_event <= 1'b0;
    tick(4);
    chk_bit(sb_bus.fatal_dev_oe, 1'b0, "no drive when tristate");
    @(posedge clk) hot_req <= 1'b0;
    rst_on();
    rst_off();
    chk_bit(outputs_tristate, 1'b0, "tristate cleared");
    @(posedge clk) die_crit_temp <= 1'b1;
    tick(6);
    chk_vec({sb_bus.thermal_trip_n, trip_seen, execution_halt}, 3'h3, "thermal trip");
    @(posedge clk) reg_fault_event <= 1'b1;
    @(posedge clk) reg_fault_event <= 1'b0;
    tick(4);
    chk_bit(fault_seen, 1'b1, "qualified fault");
    @(posedge clk) die_crit_temp <= 1'b0;
    mem_crit_temp <= 1'b1;
    tick(10);
    chk_bit(sb_bus.thermal_trip_n, 1'b0, "trip latched");
    rst_on();
    chk_bit(sb_bus.thermal_trip_n, 1'b1, "trip cleared in reset");
    rst_off();
    chk_bit(sb_bus.thermal_trip_n, 1'b0, "trip reasserted");
    @(posedge clk) mem_crit_temp <= 1'b0;
    rst_on();
    rst_off();
    chk_bit(sb_bus.thermal_trip_n, 1'b1, "trip gone when cool");
    chk_bit(fault_seen, 1'b0, "fault unqualified");
    summarize();
  end
endmodule
`default_nettype wire
